// >>> logic/ted_consts.vh
/*
  constants for the transient event detector: register offsets,
  field positions, reset values and debounce step timing.
  assumes a 250 MHz core clock and 12-bit samples scaled to +/-8 g.
*/
`ifndef TED_CONSTS_VH
`define TED_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TED_ADDR_CONFIG 8'h1d
`define TED_ADDR_SOURCE 8'h1e
`define TED_ADDR_THRESHOLD 8'h1f
`define TED_ADDR_COUNT 8'h20

// ----------------------------------------
// transient_config fields
// ----------------------------------------
`define TED_CFG_LATCH_BIT 4
`define TED_CFG_Z_EN_BIT 3
`define TED_CFG_Y_EN_BIT 2
`define TED_CFG_X_EN_BIT 1
`define TED_CFG_BYPASS_BIT 0
`define TED_CFG_RESET 5'h00

// ----------------------------------------
// transient_source fields
// ----------------------------------------
`define TED_SRC_ACTIVE_BIT 6
`define TED_SRC_Z_FLAG_BIT 5
`define TED_SRC_Z_POL_BIT 4
`define TED_SRC_Y_FLAG_BIT 3
`define TED_SRC_Y_POL_BIT 2
`define TED_SRC_X_FLAG_BIT 1
`define TED_SRC_X_POL_BIT 0

// ----------------------------------------
// threshold and count fields
// ----------------------------------------
`define TED_THS_MODE_BIT 7
`define TED_THS_RESET 8'h00
`define TED_COUNT_RESET 8'h00
// one threshold lsb is 16 sample lsbs at +/-8 g scaling
`define TED_MAG_SHIFT 4

// ----------------------------------------
// step timing, microseconds and clock rate
// ----------------------------------------
`define TED_CLK_MHZ 250
`define TED_STEP_BASE_US 1250
`define TED_CAP_NORMAL_US 20000
`define TED_CAP_LNLP_US 80000
`define TED_CAP_HIRES_US 2500
`define TED_CAP_LOWPWR_US 160000

`endif

// >>> logic/ted_axis.v
/*
  one axis of the transient detector: threshold compare on the
  magnitude of a sample and the debounce counter.
  assumes i_step is a one-cycle pulse once per debounce step.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ted_consts.vh"

module ted_axis (
  input wire i_clk,
  input wire i_nrst,
  input wire i_step,
  input wire [11:0] i_sample,
  input wire [6:0] i_threshold,
  input wire i_clear_mode,
  input wire [7:0] i_count,
  output wire o_detect,
  output wire o_negative
);

  // ----------------------------------------
  // magnitude and compare
  // ----------------------------------------
  wire [11:0] mag;
  wire [7:0] mag_scaled;
  wire over;

  // -2048 folds to 2048, which still fits 12 bits unsigned
  assign mag = i_sample[11] ? (~i_sample + 12'h001) : i_sample;
  assign mag_scaled = mag[11:`TED_MAG_SHIFT];
  assign over = mag_scaled > {1'b0, i_threshold};

  // ----------------------------------------
  // debounce counter
  // ----------------------------------------
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg det_reg;
  reg det_next;
  reg neg_reg;

  always @*
  begin
    cnt_next = cnt_reg;
    if (over)
    begin
      if (cnt_reg < i_count)
        cnt_next = cnt_reg + 8'h01;
      else
        cnt_next = i_count; // RULE_17
    end
    else if (i_clear_mode)
      cnt_next = 8'h00; // RULE_16
    else if (cnt_reg != 8'h00)
      cnt_next = cnt_reg - 8'h01; // RULE_16
    det_next = over && (cnt_next == i_count); // RULE_14
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_reg <= 8'h00;
      det_reg <= 1'b0;
      neg_reg <= 1'b0;
    end
    else if (i_step)
    begin
      cnt_reg <= cnt_next;
      det_reg <= det_next;
      neg_reg <= i_sample[11]; // RULE_08
    end
  end

  assign o_detect = det_reg;
  assign o_negative = neg_reg;

endmodule // ted_axis

`default_nettype wire

// >>> logic/ted_top.v
/*
  transient event detector: configuration, threshold and count
  registers, debounce step timer, three axis detectors and the
  read-clear source register.
  assumes a synchronous register port driven by the serial
  interface logic, and 12-bit signed samples scaled to +/-8 g.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ted_consts.vh"

// Function
// RULE_01 - config bit 4 latches event flags until source is read
// RULE_02 - config bits 3,2,1 enable z, y, x event flags
// RULE_03 - config bit 0 bypasses the high-pass filter, using raw samples
// RULE_04 - reading source drops the transient interrupt request
// RULE_05 - while active, new events add flags and polarity; none clear early
// RULE_06 - source bit 6 is event active, set when any axis flag set
// RULE_07 - source bits 5,3,1 are z, y, x event flags
// RULE_08 - source bits 4,2,0 hold z, y, x polarity, 1 is negative
// RULE_09 - when active sets with latching, other status bits freeze; here new axis flags still set, only set axes keep polarity
// RULE_10 - reading source clears all its status bits
// RULE_11 - filtered sample above threshold raises flag and interrupt
// RULE_12 - threshold bit 7 is debounce mode, bits 6..0 threshold
// RULE_13 - detection spans +/-8 g whatever the full-scale setting
// RULE_14 - count register sets consecutive steps needed before flagging
// RULE_15 - step period follows sample rate and oversampling mode caps
// RULE_16 - on false condition, mode 1 clears, mode 0 decrements counter
// RULE_17 - flag sets when counter reaches count; counter never exceeds it
// RULE_18 - without latching, flags follow the debounced result each step
module ted_top #(
  parameter P_BASE_STEP_CYC = `TED_STEP_BASE_US * `TED_CLK_MHZ
) (
  input wire i_clk,
  input wire i_nrst,
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_rd,
  output wire [7:0] o_reg_rdata,
  input wire [2:0] i_output_sample_rate,
  input wire [1:0] i_oversample_mode,
  input wire [11:0] i_x_raw,
  input wire [11:0] i_y_raw,
  input wire [11:0] i_z_raw,
  input wire [11:0] i_x_filtered,
  input wire [11:0] i_y_filtered,
  input wire [11:0] i_z_filtered,
  output wire o_transient_req
);

  // ----------------------------------------
  // oversampling mode codes
  // ----------------------------------------
  localparam [1:0] MODE_NORMAL = 2'h0;
  localparam [1:0] MODE_LNLP = 2'h1;
  localparam [1:0] MODE_HIRES = 2'h2;
  localparam [1:0] MODE_LOW_POWER = 2'h3;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  reg [4:0] cfg_reg;
  reg [7:0] ths_reg;
  reg [7:0] count_reg;
  reg [7:0] rdata_reg;

  wire flag_latch_enable;
  wire z_event_enable;
  wire y_event_enable;
  wire x_event_enable;
  wire filter_bypass;
  wire debounce_mode_select;
  wire [6:0] threshold_value;

  assign flag_latch_enable = cfg_reg[`TED_CFG_LATCH_BIT]; // RULE_01
  assign z_event_enable = cfg_reg[`TED_CFG_Z_EN_BIT]; // RULE_02
  assign y_event_enable = cfg_reg[`TED_CFG_Y_EN_BIT]; // RULE_02
  assign x_event_enable = cfg_reg[`TED_CFG_X_EN_BIT]; // RULE_02
  assign filter_bypass = cfg_reg[`TED_CFG_BYPASS_BIT]; // RULE_03
  assign debounce_mode_select = ths_reg[`TED_THS_MODE_BIT]; // RULE_12
  assign threshold_value = ths_reg[6:0]; // RULE_12

  wire wr_cfg;
  wire wr_ths;
  wire wr_count;
  wire rd_source;

  assign wr_cfg = i_reg_wr && (i_reg_addr == `TED_ADDR_CONFIG);
  assign wr_ths = i_reg_wr && (i_reg_addr == `TED_ADDR_THRESHOLD);
  assign wr_count = i_reg_wr && (i_reg_addr == `TED_ADDR_COUNT);
  assign rd_source = i_reg_rd && (i_reg_addr == `TED_ADDR_SOURCE);

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cfg_reg <= `TED_CFG_RESET;
    else if (wr_cfg)
      cfg_reg <= i_reg_wdata[4:0];
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ths_reg <= `TED_THS_RESET;
    else if (wr_ths)
      ths_reg <= i_reg_wdata;
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      count_reg <= `TED_COUNT_RESET;
    else if (wr_count)
      count_reg <= i_reg_wdata; // RULE_14
  end

  // ----------------------------------------
  // debounce step timer
  // ----------------------------------------
  // the step is a whole number of base periods, so one prescaler
  // plus a small multiple counter covers every rate and mode
  function [31:0] rate_period_us;
    input [2:0] rate;
    begin
      case (rate)
        3'h0: rate_period_us = `TED_STEP_BASE_US;
        3'h1: rate_period_us = `TED_STEP_BASE_US * 2;
        3'h2: rate_period_us = `TED_STEP_BASE_US * 4;
        3'h3: rate_period_us = `TED_STEP_BASE_US * 8;
        3'h4: rate_period_us = `TED_STEP_BASE_US * 16;
        3'h5: rate_period_us = `TED_STEP_BASE_US * 64;
        3'h6: rate_period_us = `TED_STEP_BASE_US * 128;
        default: rate_period_us = `TED_STEP_BASE_US * 512;
      endcase
    end
  endfunction

  function [31:0] mode_cap_us;
    input [1:0] mode;
    begin
      case (mode)
        MODE_NORMAL: mode_cap_us = `TED_CAP_NORMAL_US;
        MODE_LNLP: mode_cap_us = `TED_CAP_LNLP_US;
        MODE_HIRES: mode_cap_us = `TED_CAP_HIRES_US;
        MODE_LOW_POWER: mode_cap_us = `TED_CAP_LOWPWR_US;
        default: mode_cap_us = `TED_CAP_NORMAL_US;
      endcase
    end
  endfunction

  reg [31:0] step_us;
  reg [31:0] step_mult_full;
  wire [9:0] step_mult;

  always @*
  begin
    step_us = rate_period_us(i_output_sample_rate);
    if (step_us > mode_cap_us(i_oversample_mode))
      step_us = mode_cap_us(i_oversample_mode); // RULE_15
    step_mult_full = step_us / `TED_STEP_BASE_US;
  end

  assign step_mult = step_mult_full[9:0];

  reg [19:0] base_cnt_reg;
  reg [9:0] mult_cnt_reg;
  reg step_reg;
  wire base_tick;
  wire mult_last;

  assign base_tick = (base_cnt_reg == P_BASE_STEP_CYC[19:0] - 20'h00001);
  assign mult_last = (mult_cnt_reg >= step_mult - 10'h001);

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      base_cnt_reg <= 20'h00000;
      mult_cnt_reg <= 10'h000;
      step_reg <= 1'b0;
    end
    else
    begin
      step_reg <= 1'b0;
      if (base_tick)
      begin
        base_cnt_reg <= 20'h00000;
        if (mult_last)
        begin
          mult_cnt_reg <= 10'h000;
          step_reg <= 1'b1; // RULE_15
        end
        else
          mult_cnt_reg <= mult_cnt_reg + 10'h001;
      end
      else
        base_cnt_reg <= base_cnt_reg + 20'h00001;
    end
  end

  // ----------------------------------------
  // sample select and axis detectors
  // ----------------------------------------
  // samples arrive at +/-8 g scaling, so the compare is unaffected
  // by the full-scale range chosen for the output registers
  wire [35:0] samples;
  wire [2:0] det;
  wire [2:0] neg;

  assign samples = filter_bypass ?
    {i_z_raw, i_y_raw, i_x_raw} :
    {i_z_filtered, i_y_filtered, i_x_filtered}; // RULE_03 RULE_11 RULE_13

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_axis
      ted_axis u_axis (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_step(step_reg),
        .i_sample(samples[g*12 +: 12]),
        .i_threshold(threshold_value),
        .i_clear_mode(debounce_mode_select),
        .i_count(count_reg),
        .o_detect(det[g]),
        .o_negative(neg[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // flag update strobe
  // ----------------------------------------
  // the axis detect registers load on the step edge, so the flags
  // take them one cycle later, once they hold this step's result
  reg step_d_reg;

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      step_d_reg <= 1'b0;
    else
      step_d_reg <= step_reg; // RULE_17
  end

  // ----------------------------------------
  // source register
  // ----------------------------------------
  // index 0 is x, 1 is y, 2 is z
  reg [2:0] flag_reg;
  reg [2:0] pol_reg;
  reg [2:0] flag_next;
  reg [2:0] pol_next;
  reg [2:0] base_flag;
  reg [2:0] base_pol;
  wire [2:0] axis_en;
  wire [2:0] hit;
  wire event_active;

  assign axis_en = {z_event_enable, y_event_enable, x_event_enable};
  assign hit = det & axis_en; // RULE_02 RULE_11

  // a step landing in the read cycle is applied after the clear,
  // so the fresh event survives the read
  always @*
  begin
    base_flag = rd_source ? 3'h0 : flag_reg; // RULE_10
    base_pol = rd_source ? 3'h0 : pol_reg; // RULE_10
    flag_next = base_flag;
    pol_next = base_pol;
    if (step_d_reg)
    begin
      if (flag_latch_enable)
      begin
        // a set axis keeps its polarity; only a newly set axis writes one
        flag_next = base_flag | hit; // RULE_05 RULE_01
        pol_next = (base_flag & base_pol) | (~base_flag & hit & neg); // RULE_05 RULE_09
      end
      else
      begin
        flag_next = hit; // RULE_18
        pol_next = hit & neg; // RULE_18 RULE_08
      end
    end
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      flag_reg <= 3'h0;
      pol_reg <= 3'h0;
    end
    else
    begin
      flag_reg <= flag_next; // RULE_07
      pol_reg <= pol_next; // RULE_08
    end
  end

  assign event_active = |flag_reg; // RULE_06

  // ----------------------------------------
  // read data
  // ----------------------------------------
  reg [7:0] source_value;

  always @*
  begin
    source_value = 8'h00;
    source_value[`TED_SRC_ACTIVE_BIT] = event_active; // RULE_06
    source_value[`TED_SRC_Z_FLAG_BIT] = flag_reg[2]; // RULE_07
    source_value[`TED_SRC_Z_POL_BIT] = pol_reg[2]; // RULE_08
    source_value[`TED_SRC_Y_FLAG_BIT] = flag_reg[1]; // RULE_07
    source_value[`TED_SRC_Y_POL_BIT] = pol_reg[1]; // RULE_08
    source_value[`TED_SRC_X_FLAG_BIT] = flag_reg[0]; // RULE_07
    source_value[`TED_SRC_X_POL_BIT] = pol_reg[0]; // RULE_08
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_reg <= 8'h00;
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        `TED_ADDR_CONFIG: rdata_reg <= {3'h0, cfg_reg};
        `TED_ADDR_SOURCE: rdata_reg <= source_value;
        `TED_ADDR_THRESHOLD: rdata_reg <= ths_reg;
        `TED_ADDR_COUNT: rdata_reg <= count_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign o_reg_rdata = rdata_reg;

  // ----------------------------------------
  // interrupt request
  // ----------------------------------------
  // follows the active flag, so the read that clears the flags
  // also drops the request on the next edge
  assign o_transient_req = event_active; // RULE_04 RULE_11

endmodule // ted_top

`default_nettype wire

// >>> tb/ted_props.sv
/* checker for the register port and request output of ted_top.
   sees only top ports; bound to the top below. */
`timescale 1ns/100ps
`default_nettype none
module ted_props (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_transient_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_rd_src;
    i_reg_rd && i_reg_addr == 8'h1e;
  endsequence
  sequence s_wr_rd(a);
    i_reg_wr && i_reg_addr == a ##2 i_reg_rd && i_reg_addr == a;
  endsequence
  property p_rst;
    disable iff (1'b0) !i_nrst |-> o_reg_rdata == 8'h00 && !o_transient_req;
  endproperty
  property p_cfg_rd;
    s_wr_rd(8'h1d) |=> o_reg_rdata == ($past(i_reg_wdata, 3) & 8'h1f);
  endproperty
  property p_ths_rd;
    s_wr_rd(8'h1f) |=> o_reg_rdata == $past(i_reg_wdata, 3);
  endproperty
  property p_cnt_rd;
    s_wr_rd(8'h20) |=> o_reg_rdata == $past(i_reg_wdata, 3);
  endproperty
  property p_src_hi;
    s_rd_src |=> !o_reg_rdata[7];
  endproperty
  property p_ea;
    s_rd_src |=> o_reg_rdata[6] == (o_reg_rdata[5] | o_reg_rdata[3] | o_reg_rdata[1]);
  endproperty
  property p_pol;
    s_rd_src |=> o_reg_rdata[4] <= o_reg_rdata[5] && o_reg_rdata[2] <= o_reg_rdata[3]
      && o_reg_rdata[0] <= o_reg_rdata[1];
  endproperty
  // read data must not drift between reads
  property p_stand;
    !i_reg_rd |=> $stable(o_reg_rdata);
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs not zero");
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback");
  a_ths_rd: assert property (p_ths_rd) else $error("threshold readback");
  a_cnt_rd: assert property (p_cnt_rd) else $error("count readback");
  a_src_hi: assert property (p_src_hi) else $error("source bit 7 set");
  a_ea: assert property (p_ea) else $error("active flag wrong");
  a_pol: assert property (p_pol) else $error("polarity without flag");
  a_stand: assert property (p_stand) else $error("read data moved");
endmodule // ted_props
bind ted_top ted_props u_props (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_transient_req(o_transient_req));
`default_nettype wire

// >>> tb/ted_host.sv
/* host model driving the register strobe port.
   assumes each task is entered just after a rising edge. */
`timescale 1ns/100ps
`default_nettype none
module ted_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd
);
  initial
  begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end
  // ----------------------------------------
  // one access per task, strobe held one edge
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    // idle edge, so a following strobe never toggles in this time step
    @(posedge i_clk);
    #1;
  endtask
  // data lands on the read edge, so it is taken right after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    d = i_rdata;
    @(posedge i_clk);
    #1;
  endtask
endmodule // ted_host
`default_nettype wire

// >>> tb/test_ted_top.sv
/* testbench for ted_top with the host model.
   short base step of 8 cycles keeps debounce runs brief. */
`timescale 1ns/100ps
`default_nettype none
module test_ted_top;
  logic i_clk;
  logic i_nrst;
  wire logic [7:0] addr, wdata, rdata;
  wire logic wr, rd, req;
  logic [2:0] rate = 3'h0;
  logic [1:0] osm = 2'h0;
  logic [11:0] xr = 12'h000, yr = 12'h000, zr = 12'h000;
  logic [11:0] xf = 12'h000, yf = 12'h000, zf = 12'h000;
  int mismatches = 0;
  int n_tests = 0;
  ted_host host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_wdata(wdata), .o_rd(rd));
  ted_top #(.P_BASE_STEP_CYC(8)) DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_output_sample_rate(rate), .i_oversample_mode(osm), .i_x_raw(xr), .i_y_raw(yr),
    .i_z_raw(zr), .i_x_filtered(xf), .i_y_filtered(yf), .i_z_filtered(zf),
    .o_transient_req(req));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task end_sim;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    rdc(8'h1d, 8'h00);
    rdc(8'h1e, 8'h00);
    rdc(8'h1f, 8'h00);
    rdc(8'h20, 8'h00);
    rdc(8'h30, 8'h00);
    host.wr(8'h1d, 8'hff);
    rdc(8'h1d, 8'h1f);
    host.wr(8'h1f, 8'ha5);
    rdc(8'h1f, 8'ha5);
    host.wr(8'h20, 8'hff);
    rdc(8'h20, 8'hff);
    host.wr(8'h1e, 8'hff);
    rdc(8'h1e, 8'h00);
    host.wr(8'h1d, 8'h12);
    host.wr(8'h1f, 8'h10);
  endtask
  // p is the step period in cycles; n over steps flag, one when n is 0
  task t_timing(input logic [2:0] r, input logic [1:0] m, input int p, input logic [7:0] n);
    host.wr(8'h20, n);
    rate = r;
    osm = m;
    tick(4 * p);
    xf = 12'he00;
    tick((n > 1 ? n - 1 : 0) * p + 1);
    chk({7'h00, req}, 8'h00);
    tick(p);
    chk({7'h00, req}, 8'h01);
    xf = 12'h000;
    tick(p + 1);
    rdc(8'h1e, 8'h43);
    chk({7'h00, req}, 8'h00);
  endtask
  task t_latch;
    host.wr(8'h1d, 8'h16);
    host.wr(8'h20, 8'h00);
    xf = 12'he00;
    tick(16);
    xf = 12'h200;
    yf = 12'h200;
    tick(16);
    xf = 12'h000;
    yf = 12'h000;
    tick(16);
    rdc(8'h1e, 8'h4b);
    rdc(8'h1e, 8'h00);
  endtask
  // raw path only; the filtered inputs stay quiet
  task t_unlatch;
    host.wr(8'h1d, 8'h09);
    xr = 12'h300;
    zr = 12'h100;
    tick(16);
    rdc(8'h1e, 8'h00);
    zr = 12'h110;
    tick(16);
    rdc(8'h1e, 8'h60);
    tick(16);
    chk({7'h00, req}, 8'h01);
    zr = 12'h000;
    tick(16);
    chk({7'h00, req}, 8'h00);
    xr = 12'h000;
  endtask
  task t_mode;
    host.wr(8'h1d, 8'h12);
    host.wr(8'h20, 8'h04);
    for (int m = 0; m < 2; m++)
    begin
      host.wr(8'h1f, m ? 8'h90 : 8'h10);
      xf = 12'h200;
      tick(24);
      xf = 12'h000;
      tick(8);
      xf = 12'h200;
      tick(16);
      xf = 12'h000;
      tick(40);
      rdc(8'h1e, m ? 8'h00 : 8'h42);
    end
  endtask
  // ----------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial
  begin
    i_nrst = 1'b0;
    tick(5);
    i_nrst = 1'b1;
    t_regs;
    t_timing(3'h0, 2'h0, 8, 8'h03);
    t_timing(3'h3, 2'h2, 16, 8'h02);
    t_timing(3'h3, 2'h0, 64, 8'h01);
    t_timing(3'h5, 2'h1, 512, 8'h00);
    t_timing(3'h7, 2'h3, 1024, 8'h00);
    rate = 3'h0;
    osm = 2'h0;
    tick(64);
    t_latch;
    t_unlatch;
    t_mode;
    end_sim;
  end
  // whole run is near 10200 cycles, so 25000 is ample
  initial
  begin
    #100000;
    mismatches++;
    end_sim;
  end
endmodule // test_ted_top
`default_nettype wire
